/* File: hdl/gsci_core.sv */
/*
 Command line interpreter: parses CR/LF command lines, keeps the
 configuration, answers over a byte stream; Wishbone slave for calibration writes and status.
 Assumes a UART byte receiver and transmitter on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module gsci_core
    import gsci_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire gsci_wb_req_s wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire gsci_byte_s rx_i,
    output logic rx_ready_o,
    output gsci_byte_s tx_o,
    input wire logic tx_ready_i,
    output logic cal_req_o,
    output logic [16:0] cal_conc_o,
    output logic az_start_o,
    output logic az_enable_o
);
    typedef enum logic [3:0] {
        ST_CMD = 4'b0001,
        ST_ARG = 4'b0010,
        ST_EOL = 4'b0100,
        ST_SEND = 4'b1000
    } gsci_state_e;

    // Five decimal digits in ASCII, saturating at 99999
    function automatic logic [39:0] fmt5(input logic [16:0] v);
        logic [19:0] bcd;
        logic [16:0] x;
        logic [39:0] r;
        bcd = '0;
        x = (v > NUM_MAX) ? NUM_MAX : v;
        for (int i = 16; i >= 0; i--) begin
            for (int k = 0; k < 5; k++) begin
                if (bcd[k*4+:4] >= 4'h5) begin
                    bcd[k*4+:4] = bcd[k*4+:4] + 4'h3;
                end
            end
            bcd = {bcd[18:0], x[i]};
        end
        for (int k = 0; k < 5; k++) begin
            r[k*8+:8] = {4'h3, bcd[k*4+:4]};
        end
        return r;
    endfunction : fmt5

    // Byte-lane merge for writable words
    function automatic logic [15:0] wmerge(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : wmerge

    gsci_state_e st_q, st_d;
    logic [7:0] cmd_q, cmd_d;
    logic [16:0] fld_q [NFLD], fld_d [NFLD];
    logic [NFLD-1:0] dot_q, dot_d;
    logic [1:0] fi_q, fi_d;
    logic dig_q, dig_d, bad_q, bad_d;
    logic [7:0] buf_q [BUF_DEPTH], buf_d [BUF_DEPTH];
    logic [5:0] len_q, len_d, idx_q, idx_d;
    gsci_byte_s tx_q, tx_d;
    logic rxr_q, rxr_d;
    logic [15:0] alt_q, alt_d, bgaz_q, bgaz_d, bgfr_q, bgfr_d;
    logic [15:0] init_q, init_d, regl_q, regl_d;
    logic azen_q, azen_d, azgo_q, azgo_d, cal_q, cal_d;
    logic [16:0] conc_q, conc_d;
    logic [15:0] mult_q, mult_d, zero_q, zero_d;
    logic [31:0] rdat_q, rdat_d;
    logic ack_q, ack_d;
    logic take_w, exec_w;
    logic [32:0] prod_w;
    logic [1:0] nf_w;

    assign take_w = rx_i.valid && rxr_q;
    assign exec_w = (st_q == ST_EOL) && take_w && rx_i.data == CH_LF;
    assign nf_w = fi_q + {1'b0, dig_q};
    assign prod_w = fld_q[0] * mult_q;

    // ----------------------------------------
    // Line parser and reply builder
    // ----------------------------------------
    always_comb begin
        logic [39:0] f;
        logic [15:0] iv;
        logic [5:0] n;
        logic lead;
        f = '0;
        iv = '0;
        n = '0;
        lead = 1'b0;
        st_d = st_q;
        cmd_d = cmd_q;
        fld_d = fld_q;
        dot_d = dot_q;
        fi_d = fi_q;
        dig_d = dig_q;
        bad_d = bad_q;
        buf_d = buf_q;
        len_d = len_q;
        idx_d = idx_q;
        tx_d = tx_q;
        alt_d = alt_q;
        bgaz_d = bgaz_q;
        bgfr_d = bgfr_q;
        init_d = init_q;
        regl_d = regl_q;
        azen_d = azen_q;
        azgo_d = 1'b0;
        cal_d = 1'b0;
        conc_d = conc_q;
        unique case (st_q)
            ST_CMD: begin
                // Stray terminators and spaces between lines are skipped
                if (take_w && rx_i.data != CH_CR && rx_i.data != CH_LF && rx_i.data != CH_SP) begin
                    cmd_d = rx_i.data;
                    for (int j = 0; j < NFLD; j++) begin
                        fld_d[j] = '0;
                    end
                    dot_d = '0;
                    fi_d = '0;
                    dig_d = 1'b0;
                    bad_d = 1'b0;
                    st_d = ST_ARG;
                end
            end
            ST_ARG: begin
                if (take_w) begin
                    if (rx_i.data == CH_CR) begin
                        st_d = ST_EOL;
                    end else if (rx_i.data == CH_SP) begin
                        if (dig_q) begin
                            bad_d = bad_q || fi_q == 2'd2;
                            fi_d = (fi_q == 2'd2) ? fi_q : fi_q + 2'd1;
                            dig_d = 1'b0;
                        end
                    end else if (rx_i.data == CH_DOT) begin
                        dot_d[fi_q] = 1'b1;
                    end else if (rx_i.data >= 8'h30 && rx_i.data <= 8'h39) begin
                        fld_d[fi_q] = 17'(fld_q[fi_q] * 17'd10 + 17'(rx_i.data - 8'h30));
                        dig_d = 1'b1;
                    end else begin
                        bad_d = 1'b1;
                    end
                end
            end
            ST_EOL: begin
                if (take_w && rx_i.data != CH_LF) begin
                    bad_d = 1'b1;
                    st_d = (rx_i.data == CH_CR) ? ST_EOL : ST_ARG;
                end else if (exec_w) begin
                    st_d = ST_CMD;
                    buf_d[0] = cmd_q;
                    buf_d[1] = CH_SP;
                    if (bad_q) begin
                        n = '0;
                    end else if (cmd_q == CH_X && nf_w == 2'd1) begin
                        cal_d = 1'b1;
                        conc_d = (prod_w > 33'(17'h1ffff)) ? 17'h1ffff : prod_w[16:0];
                        f = fmt5({1'b0, zero_q});
                        n = 6'd2;
                    end else if (cmd_q == CH_S && nf_w == 2'd1) begin
                        alt_d = fld_q[0][15:0];
                        f = fmt5({1'b0, fld_q[0][15:0]});
                        n = 6'd2;
                    end else if (cmd_q == CH_SL && nf_w == 2'd0) begin
                        f = fmt5({1'b0, alt_q});
                        n = 6'd2;
                    end else if (cmd_q == CH_P && nf_w == 2'd2) begin
                        n = 6'd2;
                        unique case (fld_q[0])
                            PIDX_AZ_HI: bgaz_d[15:8] = fld_q[1][7:0];
                            PIDX_AZ_LO: bgaz_d[7:0] = fld_q[1][7:0];
                            PIDX_FR_HI: bgfr_d[15:8] = fld_q[1][7:0];
                            PIDX_FR_LO: bgfr_d[7:0] = fld_q[1][7:0];
                            default: n = '0;
                        endcase
                        f = fmt5(fld_q[0]);
                        for (int k = 0; k < 5; k++) begin
                            buf_d[2+k] = f[(4-k)*8+:8];
                        end
                        buf_d[7] = CH_SP;
                        f = fmt5({9'h000, fld_q[1][7:0]});
                        n = (n == '0) ? n : 6'd8;
                    end else if (cmd_q == CH_Y && nf_w == 2'd0) begin
                        buf_d[1] = CH_COMMA;
                        for (int k = 0; k < 8; k++) begin
                            buf_d[2+k] = FW_VERSION[(7-k)*8+:8];
                        end
                        buf_d[10] = CH_CR;
                        buf_d[11] = CH_LF;
                        buf_d[12] = CH_B;
                        buf_d[13] = CH_SP;
                        f = fmt5(SERIAL_HI);
                        for (int k = 0; k < 5; k++) begin
                            buf_d[14+k] = f[(4-k)*8+:8];
                        end
                        buf_d[19] = CH_SP;
                        f = fmt5(SERIAL_LO);
                        n = 6'd20;
                    end else if (cmd_q == CH_AT) begin
                        n = 6'd1;
                        if (nf_w == 2'd2) begin
                            init_d = dot_q[0] ? fld_q[0][15:0] : 16'(fld_q[0] * 17'd10);
                            regl_d = dot_q[1] ? fld_q[1][15:0] : 16'(fld_q[1] * 17'd10);
                            azen_d = 1'b1;
                        end else if (nf_w == 2'd1 && fld_q[0] == '0) begin
                            azen_d = 1'b0;
                        end else if (nf_w == 2'd1 && fld_q[0] == AZ_NOW_CODE) begin
                            azgo_d = 1'b1;
                        end else if (nf_w != 2'd0) begin
                            n = '0;
                        end
                        // Report form doubles as echo and as query answer
                        if (n != '0 && !azen_d) begin
                            buf_d[1] = CH_SP;
                            buf_d[2] = 8'h30;
                            n = 6'd3;
                        end else if (n != '0) begin
                            for (int j = 0; j < 2; j++) begin
                                iv = (j == 0) ? init_d : regl_d;
                                f = fmt5({1'b0, iv});
                                buf_d[n[4:0]] = CH_SP;
                                n = n + 6'd1;
                                lead = 1'b0;
                                for (int k = 0; k < 4; k++) begin
                                    if (lead || f[(4-k)*8+:8] != 8'h30 || k == 3) begin
                                        buf_d[n[4:0]] = f[(4-k)*8+:8];
                                        n = n + 6'd1;
                                        lead = 1'b1;
                                    end
                                end
                                buf_d[n[4:0]] = CH_DOT;
                                buf_d[n[4:0]+5'd1] = f[7:0];
                                n = n + 6'd2;
                            end
                        end
                    end
                    // Five padded digits follow the prefix (none for @), then CR LF
                    if (n != '0 && cmd_q != CH_AT) begin
                        for (int k = 0; k < 5; k++) begin
                            buf_d[n[4:0]+5'(k)] = f[(4-k)*8+:8];
                        end
                        n = n + 6'd5;
                    end
                    if (n != '0) begin
                        buf_d[n[4:0]] = CH_CR;
                        buf_d[n[4:0]+5'd1] = CH_LF;
                        len_d = n + 6'd2;
                        idx_d = '0;
                        st_d = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                if (!tx_q.valid || tx_ready_i) begin
                    if (idx_q < len_q) begin
                        tx_d.valid = 1'b1;
                        tx_d.data = buf_q[idx_q[4:0]];
                        idx_d = idx_q + 6'd1;
                    end else begin
                        tx_d.valid = 1'b0;
                        st_d = ST_CMD;
                    end
                end
            end
        endcase
        // Input stalls while a reply drains; no line overlaps a reply
        rxr_d = (st_d != ST_SEND);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_CMD;
            cmd_q <= '0;
            fld_q <= '{default: '0};
            dot_q <= '0;
            fi_q <= '0;
            dig_q <= 1'b0;
            bad_q <= 1'b0;
            buf_q <= '{default: '0};
            len_q <= '0;
            idx_q <= '0;
            tx_q <= '0;
            rxr_q <= 1'b0;
            alt_q <= ALT_RST;
            bgaz_q <= BG_RST;
            bgfr_q <= BG_RST;
            init_q <= INIT_RST;
            regl_q <= REGL_RST;
            azen_q <= 1'b1;
            azgo_q <= 1'b0;
            cal_q <= 1'b0;
            conc_q <= '0;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            fld_q <= fld_d;
            dot_q <= dot_d;
            fi_q <= fi_d;
            dig_q <= dig_d;
            bad_q <= bad_d;
            buf_q <= buf_d;
            len_q <= len_d;
            idx_q <= idx_d;
            tx_q <= tx_d;
            rxr_q <= rxr_d;
            alt_q <= alt_d;
            bgaz_q <= bgaz_d;
            bgfr_q <= bgfr_d;
            init_q <= init_d;
            regl_q <= regl_d;
            azen_q <= azen_d;
            azgo_q <= azgo_d;
            cal_q <= cal_d;
            conc_q <= conc_d;
        end
    end

    // ----------------------------------------
    // Wishbone slave, one wait state
    // ----------------------------------------
    always_comb begin
        ack_d = wb_i.cyc && wb_i.stb && !ack_q;
        mult_d = mult_q;
        zero_d = zero_q;
        rdat_d = '0;
        if (ack_d && wb_i.we) begin
            if (wb_i.adr == REG_MULT) mult_d = wmerge(mult_q, wb_i.dat, wb_i.sel);
            if (wb_i.adr == REG_ZERO) zero_d = wmerge(zero_q, wb_i.dat, wb_i.sel);
        end else if (ack_d) begin
            unique case (wb_i.adr)
                REG_MULT: rdat_d = {16'h0000, mult_q};
                REG_ZERO: rdat_d = {16'h0000, zero_q};
                REG_ALT: rdat_d = {16'h0000, alt_q};
                REG_BG: rdat_d = {bgfr_q, bgaz_q};
                REG_INTV: rdat_d = {regl_q, init_q};
                REG_STAT: rdat_d = {30'h00000000, st_q == ST_SEND, azen_q};
                default: rdat_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
            mult_q <= MULT_RST;
            zero_q <= ZERO_RST;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            mult_q <= mult_d;
            zero_q <= zero_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign rx_ready_o = rxr_q;
    assign tx_o = tx_q;
    assign cal_req_o = cal_q;
    assign cal_conc_o = conc_q;
    assign az_start_o = azgo_q;
    assign az_enable_o = azen_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_follows_req: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    // Not gated by reset: it must look at the first edge after release
    a_alt_reset_dflt: assert property (disable iff (1'b0) $fell(rst_i) |-> alt_q == ALT_RST)
        else $error("alt default");
    a_act_after_lf: assert property ($rose(st_q == ST_SEND) |-> $past(rx_i.data) == CH_LF) else $error("early act");
    // Full-width product, so a wrapped result cannot pass
    a_cal_scaled: assert property (cal_req_o |->
        {16'h0000, cal_conc_o} == 33'($past(fld_q[0])) * 33'($past(mult_q)) || cal_conc_o == 17'h1ffff)
        else $error("bad scale");
    a_cal_reply: assert property (cal_req_o |-> st_q == ST_SEND && buf_q[0] == CH_X) else $error("X reply");
    a_az_now: assert property (az_start_o |-> $past(cmd_q == CH_AT && fld_q[0] == AZ_NOW_CODE)) else $error("az");
    a_az_disable: assert property (exec_w && cmd_q == CH_AT && nf_w == 2'd1 && fld_q[0] == '0 && !bad_q
        |=> !az_enable_o) else $error("az off");
    a_bg_hi_byte: assert property (exec_w && cmd_q == CH_P && nf_w == 2'd2
        && fld_q[0] == PIDX_AZ_HI && !bad_q |=> bgaz_q[15:8] == $past(fld_q[1][7:0])) else $error("bg hi");
    a_line_ends_lf: assert property (st_q == ST_SEND && idx_q == len_q && tx_o.valid
        |-> tx_o.data == CH_LF) else $error("no LF");
    a_rx_stalled: assert property (st_q == ST_SEND |-> !rx_ready_o) else $error("rx open");
    c_cal_cmd: cover property (cal_req_o);
    c_ident_cmd: cover property (exec_w && cmd_q == CH_Y);
    c_az_query: cover property (exec_w && cmd_q == CH_AT && nf_w == 2'd0);
endmodule : gsci_core
`default_nettype wire

/* File: inc/gsci_pkg.sv */
/*
 Shared constants and carriers for the gas sensor command interpreter.
 Assumes one 100 MHz clock and a byte-wide serial front end outside.
*/
`default_nettype none
package gsci_pkg;
    // ----------------------------------------
    // Characters
    // ----------------------------------------
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_X = 8'h58;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_SL = 8'h73;
    localparam logic [7:0] CH_AT = 8'h40;
    localparam logic [7:0] CH_Y = 8'h59;
    localparam logic [7:0] CH_B = 8'h42;
    // ----------------------------------------
    // Argument codes and sizes
    // ----------------------------------------
    localparam logic [16:0] PIDX_AZ_HI = 17'h00008;
    localparam logic [16:0] PIDX_AZ_LO = 17'h00009;
    localparam logic [16:0] PIDX_FR_HI = 17'h0000a;
    localparam logic [16:0] PIDX_FR_LO = 17'h0000b;
    localparam logic [16:0] AZ_NOW_CODE = 17'h0fec6;
    localparam logic [16:0] NUM_MAX = 17'h1869f;
    localparam int BUF_DEPTH = 32;
    localparam int NFLD = 3;
    // ----------------------------------------
    // Register map and reset values
    // ----------------------------------------
    localparam logic [7:0] REG_MULT = 8'h00;
    localparam logic [7:0] REG_ZERO = 8'h04;
    localparam logic [7:0] REG_ALT = 8'h08;
    localparam logic [7:0] REG_BG = 8'h0c;
    localparam logic [7:0] REG_INTV = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [15:0] MULT_RST = 16'h0001;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    localparam logic [15:0] ALT_RST = 16'h2000;
    localparam logic [15:0] BG_RST = 16'h0190;
    localparam logic [15:0] INIT_RST = 16'h000a;
    localparam logic [15:0] REGL_RST = 16'h0050;
    // Identity values below are arbitrary
    localparam logic [63:0] FW_VERSION = 64'h56_30_2e_30_2e_30_2d_41;
    localparam logic [16:0] SERIAL_HI = 17'h00001;
    localparam logic [16:0] SERIAL_LO = 17'h00000;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } gsci_wb_req_s;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } gsci_byte_s;
endpackage : gsci_pkg
`default_nettype wire

/* File: verification/gsci_host_model.sv */
/*
 Host controller model on the far side of the byte link.
 Assumes a single clock shared with the interpreter core.
*/
`timescale 1ns/1ps
`default_nettype none
module gsci_host_model
    import gsci_pkg::*;
(
    input wire logic clk_i,
    input wire logic slow_i,
    output gsci_byte_s rx_o,
    input wire logic rx_ready_i,
    input wire gsci_byte_s tx_i,
    output logic tx_ready_o
);
    string reply = "";
    int cyc_n = 0;
    int n_hang = 0;
    initial begin
        rx_o = '{valid: 1'b0, data: 8'hff};
        tx_ready_o = 1'b0;
    end
    // ----------------------------------------
    // Reply capture, stalling every other cycle when slow
    // ----------------------------------------
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (tx_i.valid && tx_ready_o) begin
            reply = $sformatf("%s%c", reply, tx_i.data);
        end
        tx_ready_o <= !slow_i || cyc_n[0];
    end
    // Byte held until taken; idle data shows the inverse so no stale match
    task automatic send_raw(input string s);
        int w;
        logic r;
        for (int i = 0; i < s.len(); i++) begin
            rx_o <= '{valid: 1'b1, data: s[i]};
            w = 0;
            do begin
                @(posedge clk_i);
                r = rx_ready_i;
                w++;
            end while (!r && w < 3000);
            // A byte never taken is a hang; the bench ends the run on it
            if (!r) n_hang++;
            rx_o <= '{valid: 1'b0, data: ~s[i]};
            @(posedge clk_i);
        end
    endtask : send_raw
endmodule : gsci_host_model
`default_nettype wire

/* File: verification/tb_gsci_core.sv */
/*
 Self-checking bench for the command interpreter core.
 Assumes the host model drives the byte link; bench drives Wishbone.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_gsci_core
    import gsci_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic slow = 1'b0;
    gsci_wb_req_s wb_q = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rx_ready_o, tx_ready, cal_req_o, az_start_o, az_enable_o;
    logic [16:0] cal_conc_o;
    logic [16:0] conc_seen = '0;
    logic [31:0] rd;
    gsci_byte_s rx, tx;
    int n_fail = 0, tests_run = 0, n_cal = 0, n_az = 0;
    typedef struct { string cmd; string rsp; } gsci_row_s;
    gsci_row_s rows [10];
    always #5 clk_i = ~clk_i;
    gsci_core i_gsci_core (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_i(rx), .rx_ready_o(rx_ready_o), .tx_o(tx), .tx_ready_i(tx_ready),
        .cal_req_o(cal_req_o), .cal_conc_o(cal_conc_o), .az_start_o(az_start_o),
        .az_enable_o(az_enable_o));
    gsci_host_model i_gsci_host_model (.clk_i(clk_i), .slow_i(slow), .rx_o(rx),
        .rx_ready_i(rx_ready_o), .tx_i(tx), .tx_ready_o(tx_ready));
    // Pulse monitor: one-cycle strobes are counted where they stand
    always @(posedge clk_i) begin
        if (cal_req_o === 1'b1) begin
            n_cal++;
            conc_seen = cal_conc_o;
        end
        if (az_start_o === 1'b1) n_az++;
    end
    // ----------------------------------------
    // Report and compare tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic chk_str(input string got, input string exp);
        tests_run++;
        if (got != exp) begin
            n_fail++;
            $display("[ERR] %0t reply mismatch, %0d bytes against %0d expected", $time, got.len(), exp.len());
        end
    endtask : chk_str
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    // Classic cycle; held until ack is seen at a rising edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: a, dat: wd};
        do begin
            @(posedge clk_i);
            w++;
        end while (wb_ack_o !== 1'b1 && w < 100);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t no bus answer", $time);
            stop_test();
        end else begin
            rd = wb_dat_o;
            wb_q <= '0;
            @(posedge clk_i);
        end
    endtask : wb
    // Sends raw bytes and compares the whole reply
    task automatic run(input string s, input string exp);
        int w;
        w = 0;
        i_gsci_host_model.reply = "";
        i_gsci_host_model.send_raw(s);
        while (i_gsci_host_model.reply.len() < exp.len() && w < 3000) begin
            @(posedge clk_i);
            w++;
        end
        if (i_gsci_host_model.n_hang != 0 || i_gsci_host_model.reply.len() < exp.len()) begin
            n_fail++;
            $display("[ERR] %0t link wait ran out", $time);
            stop_test();
        end else begin
            repeat (30) @(posedge clk_i);
            chk_str(i_gsci_host_model.reply, exp);
        end
    endtask : run
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{"s", "s 08192\r\n"};
        rows[1] = '{"S 1234", "S 01234\r\n"};
        rows[2] = '{"s", "s 01234\r\n"};
        rows[3] = '{$sformatf("P 10 %0d", 2000 / 256), "P 00010 00007\r\n"};
        rows[4] = '{$sformatf("P 11 %0d", 2000 - 256 * 7), "P 00011 00208\r\n"};
        // 1000 ppm differs from the reset level, so the write is visible
        rows[5] = '{$sformatf("P 8 %0d", 1000 / 256), "P 00008 00003\r\n"};
        rows[6] = '{$sformatf("P 9 %0d", 1000 - 256 * 3), "P 00009 00232\r\n"};
        rows[7] = '{"@ 2.0 9.5", "@ 2.0 9.5\r\n"};
        rows[8] = '{"@", "@ 2.0 9.5\r\n"};
        rows[9] = '{"Y", $sformatf("Y,%s\r\nB %05d %05d\r\n", FW_VERSION, SERIAL_HI, SERIAL_LO)};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_val({29'h0, rx_ready_o, az_enable_o, cal_req_o}, 32'h6);
        wb(1'b0, REG_ALT, '0);
        chk_val(rd, {16'h0, ALT_RST});
        wb(1'b0, REG_BG, '0);
        chk_val(rd, 32'h0190_0190);
        wb(1'b0, 8'hfc, '0);
        chk_val(rd, 32'h0);
        // Table pass; odd rows stall the reply side
        for (int i = 0; i < 10; i++) begin
            slow <= i[0];
            run({rows[i].cmd, "\r\n"}, rows[i].rsp);
        end
        wb(1'b0, REG_BG, '0);
        chk_val(rd, 32'h07d0_03e8);
        // Nothing may happen before the full terminator
        run("s\r", "");
        run("\n", "s 01234\r\n");
        run("Q 1\r\n", "");
        run("S 1x\r\n", "");
        wb(1'b1, REG_ALT, 32'h7);
        wb(1'b0, REG_ALT, '0);
        chk_val(rd, 32'h04d2);
        wb(1'b1, REG_MULT, 32'h3);
        wb(1'b1, REG_ZERO, 32'h1234);
        run("X 1000\r\n", "X 04660\r\n");
        chk_val(n_cal, 32'd1);
        chk_val({15'h0, conc_seen}, {15'h0, 17'd3000});
        run("@ 65222\r\n", "@ 2.0 9.5\r\n");
        chk_val(n_az, 32'd1);
        run("@ 0\r\n", "@ 0\r\n");
        chk_val({31'h0, az_enable_o}, 32'h0);
        run("@ 1.0 8.0\r\n", "@ 1.0 8.0\r\n");
        wb(1'b0, REG_INTV, '0);
        chk_val(rd, 32'h0050_000a);
        chk_val({31'h0, az_enable_o}, 32'h1);
        // Mid-run reset must bring the defaults back
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, REG_ALT, '0);
        chk_val(rd, {16'h0, ALT_RST});
        wb(1'b0, REG_STAT, '0);
        chk_val(rd, 32'h1);
        stop_test();
    end
endmodule : tb_gsci_core
`default_nettype wire
